// File: logic/tfc_pkg.sv
// Constants and types for the timer flip-flop control and event status block
package tfc_pkg;

    // Register byte addresses
    localparam logic [31:0] TFC_STAT_OFS  = 32'hfffff144;
    localparam logic [31:0] TFC_CTRL_OFS  = 32'hfffff148;
    localparam logic [31:0] TFC_MASK_OFS  = 32'hfffff14c;

    // Control register field positions
    localparam int          TFC_CMD_LSB   = 0;
    localparam int          TFC_EN_LSB    = 2;
    localparam int          TFC_FIX_LSB   = 6;

    // Values after reset
    localparam logic [3:0]  TFC_EN_RST    = 4'h0;
    localparam logic [2:0]  TFC_STAT_RST  = 3'h0;
    localparam logic [2:0]  TFC_MASK_RST  = 3'h0;
    localparam logic        TFC_TFF_RST   = 1'b0;

    // Bits that always read back as ones
    localparam logic [1:0]  TFC_FIXED_ONES = 2'h3;

    // AXI responses
    localparam logic [1:0]  TFC_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  TFC_RESP_SLVERR = 2'h2;

    // Output flip-flop commands
    typedef enum logic [1:0] {
        TFC_CMD_TOGGLE = 2'h0,
        TFC_CMD_SET    = 2'h1,
        TFC_CMD_CLEAR  = 2'h2,
        TFC_CMD_KEEP   = 2'h3
    } tfc_cmd_t;

    // Timer events, one-cycle pulses from the counter core
    typedef struct packed {
        logic capture1;
        logic capture0;
        logic match1;
        logic match0;
        logic overflow;
    } tfc_evt_t;

    // Toggle enables, in control register order bit 5 down to bit 2
    typedef struct packed {
        logic cap1;
        logic cap0;
        logic match1;
        logic match0;
    } tfc_en_t;

endpackage

// File: logic/tfc_top.sv
// Timer flip-flop control and event status registers with an AXI4-Lite slave
// How it works
// - Control bits 1:0 command the output flip-flop (00 toggle, 01 set, 10 clear, 11 keep) and read as 11.
// - With its enable set, a match against compare register one toggles the output flip-flop.
// - With its enable set, a match against compare register zero toggles the output flip-flop.
// - Enables at bits 5 and 4 gate toggling by their own events, and all four enables reset to 0.
// - Status bit 0 is set by a match against compare register zero and reads 0 otherwise.
// - Status bit 1 is set by a match against compare register one and reads 0 otherwise.
// - Status bit 2 is set by an up-counter overflow; status is read-only and resets to 0.
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/10ps
module tfc_top
    import tfc_pkg::*;
(
    // Clock and reset
    input  wire logic        CLK_I,
    input  wire logic        RSTN_I,
    // Timer events
    input  wire tfc_evt_t    EVT_I,
    // Timer output and interrupt
    output logic             TFF_O,
    output logic             IRQ_O,
    // AXI4-Lite write address
    input  wire logic        S_AXI_AWVALID_I,
    output logic             S_AXI_AWREADY_O,
    input  wire logic [31:0] S_AXI_AWADDR_I,
    input  wire logic [2:0]  S_AXI_AWPROT_I,
    // AXI4-Lite write data
    input  wire logic        S_AXI_WVALID_I,
    output logic             S_AXI_WREADY_O,
    input  wire logic [31:0] S_AXI_WDATA_I,
    input  wire logic [3:0]  S_AXI_WSTRB_I,
    // AXI4-Lite write response
    output logic             S_AXI_BVALID_O,
    input  wire logic        S_AXI_BREADY_I,
    output logic [1:0]       S_AXI_BRESP_O,
    // AXI4-Lite read address
    input  wire logic        S_AXI_ARVALID_I,
    output logic             S_AXI_ARREADY_O,
    input  wire logic [31:0] S_AXI_ARADDR_I,
    input  wire logic [2:0]  S_AXI_ARPROT_I,
    // AXI4-Lite read data
    output logic             S_AXI_RVALID_O,
    input  wire logic        S_AXI_RREADY_I,
    output logic [31:0]      S_AXI_RDATA_O,
    output logic [1:0]       S_AXI_RRESP_O
);

    logic             aw_v_r;
    logic [31:0]      aw_addr_r;
    logic             w_v_r;
    logic [7:0]       w_data_r;
    logic             w_lane_r;
    logic             bvalid_r;
    logic [1:0]       bresp_r;
    logic             rvalid_r;
    logic [31:0]      rdata_r;
    logic [1:0]       rresp_r;
    tfc_en_t          en_r;
    logic [2:0]       stat_r;
    logic [2:0]       mask_r;
    logic             tff_r;

    // Handshakes and decode
    wire              aw_take     = S_AXI_AWVALID_I && S_AXI_AWREADY_O;
    wire              w_take      = S_AXI_WVALID_I && S_AXI_WREADY_O;
    wire              ar_take     = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
    wire              wr_go       = aw_v_r && w_v_r && !bvalid_r;
    wire              wa_ctrl     = aw_addr_r[31:2] == TFC_CTRL_OFS[31:2];
    wire              wa_mask     = aw_addr_r[31:2] == TFC_MASK_OFS[31:2];
    wire              wa_stat     = aw_addr_r[31:2] == TFC_STAT_OFS[31:2];
    wire              wa_ok       = wa_ctrl || wa_mask || wa_stat;
    wire              ctrl_wr     = wr_go && wa_ctrl && w_lane_r;
    wire              mask_wr     = wr_go && wa_mask && w_lane_r;
    wire              ra_ctrl     = S_AXI_ARADDR_I[31:2] == TFC_CTRL_OFS[31:2];
    wire              ra_mask     = S_AXI_ARADDR_I[31:2] == TFC_MASK_OFS[31:2];
    wire              ra_stat     = S_AXI_ARADDR_I[31:2] == TFC_STAT_OFS[31:2];
    wire              ra_ok       = ra_ctrl || ra_mask || ra_stat;
    wire              stat_rd     = ar_take && ra_stat;
    wire tfc_cmd_t    cmd         = tfc_cmd_t'(w_data_r[TFC_CMD_LSB +: 2]);
    wire tfc_en_t     en_wdata    = tfc_en_t'(w_data_r[TFC_EN_LSB +: 4]);

    // Read-back images
    wire [7:0]        ctrl_rd_img = {TFC_FIXED_ONES, en_r, TFC_FIXED_ONES};
    wire [31:0]       rd_mux      = ra_ctrl ? {24'h0, ctrl_rd_img}
                                  : ra_mask ? {29'h0, mask_r}
                                  : ra_stat ? {29'h0, stat_r}
                                  : 32'h0;

    // Enabled events that toggle the output flip-flop
    wire              tog_m0      = EVT_I.match0 && en_r.match0;
    wire              tog_m1      = EVT_I.match1 && en_r.match1;
    wire              tog_c0      = EVT_I.capture0 && en_r.cap0;
    wire              tog_c1      = EVT_I.capture1 && en_r.cap1;
    wire              tog_evt     = tog_m0 ^ tog_m1 ^ tog_c0 ^ tog_c1;

    // Toggle, set and clear commands override events in the same cycle; keep lets events toggle
    logic             tff_nxt;
    always_comb
    begin
        tff_nxt = tff_r ^ tog_evt;
        if (ctrl_wr)
        begin
            unique case (cmd)
                TFC_CMD_TOGGLE: tff_nxt = !tff_r;
                TFC_CMD_SET:    tff_nxt = 1'b1;
                TFC_CMD_CLEAR:  tff_nxt = 1'b0;
                TFC_CMD_KEEP:   tff_nxt = tff_r ^ tog_evt;
            endcase
        end
    end

    // Sticky status: a set in the clearing read cycle survives
    wire [2:0]        stat_set    = {EVT_I.overflow,
                                     EVT_I.match1,
                                     EVT_I.match0};
    wire [2:0]        stat_nxt    = (stat_r & ~{3{stat_rd}}) | stat_set;

    // Write channel
    always_ff @(posedge CLK_I)
    begin
        if (!RSTN_I)
        begin
            aw_v_r    <= 1'b0;
            aw_addr_r <= 32'h0;
            w_v_r     <= 1'b0;
            w_data_r  <= 8'h0;
            w_lane_r  <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= TFC_RESP_OKAY;
        end
        else
        begin
            if (aw_take)
            begin
                aw_v_r    <= 1'b1;
                aw_addr_r <= S_AXI_AWADDR_I;
            end
            if (w_take)
            begin
                w_v_r    <= 1'b1;
                w_data_r <= S_AXI_WDATA_I[7:0];
                w_lane_r <= S_AXI_WSTRB_I[0];
            end
            if (wr_go)
            begin
                aw_v_r   <= 1'b0;
                w_v_r    <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r  <= wa_ok ? TFC_RESP_OKAY : TFC_RESP_SLVERR;
            end
            else if (bvalid_r && S_AXI_BREADY_I)
            begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // Read channel
    always_ff @(posedge CLK_I)
    begin
        if (!RSTN_I)
        begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0;
            rresp_r  <= TFC_RESP_OKAY;
        end
        else if (ar_take)
        begin
            rvalid_r <= 1'b1;
            rdata_r  <= rd_mux;
            rresp_r  <= ra_ok ? TFC_RESP_OKAY : TFC_RESP_SLVERR;
        end
        else if (rvalid_r && S_AXI_RREADY_I)
        begin
            rvalid_r <= 1'b0;
        end
    end

    // Control, mask, status and output flip-flop
    always_ff @(posedge CLK_I)
    begin
        if (!RSTN_I)
        begin
            en_r   <= tfc_en_t'(TFC_EN_RST);
            mask_r <= TFC_MASK_RST;
            stat_r <= TFC_STAT_RST;
            tff_r  <= TFC_TFF_RST;
        end
        else
        begin
            if (ctrl_wr)
            begin
                en_r <= en_wdata;
            end
            if (mask_wr)
            begin
                mask_r <= w_data_r[2:0];
            end
            stat_r <= stat_nxt;
            tff_r  <= tff_nxt;
        end
    end

    assign S_AXI_AWREADY_O = !aw_v_r && !bvalid_r;
    assign S_AXI_WREADY_O  = !w_v_r && !bvalid_r;
    assign S_AXI_BVALID_O  = bvalid_r;
    assign S_AXI_BRESP_O   = bresp_r;
    assign S_AXI_ARREADY_O = !rvalid_r;
    assign S_AXI_RVALID_O  = rvalid_r;
    assign S_AXI_RDATA_O   = rdata_r;
    assign S_AXI_RRESP_O   = rresp_r;
    assign TFF_O           = tff_r;
    assign IRQ_O           = |(stat_r & mask_r);

    // Checks
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);

    sequence s_ctrl_read;
        ar_take && ra_ctrl ##1 rvalid_r;
    endsequence

    sequence s_quiet;
        !ctrl_wr && !tog_evt;
    endsequence

    // A single enabled event with no software command
    sequence s_only_m0;
        !ctrl_wr && tog_m0 && !tog_m1 && !tog_c0 && !tog_c1;
    endsequence

    sequence s_only_m1;
        !ctrl_wr && tog_m1 && !tog_m0 && !tog_c0 && !tog_c1;
    endsequence

    sequence s_only_c0;
        !ctrl_wr && tog_c0 && !tog_m0 && !tog_m1 && !tog_c1;
    endsequence

    sequence s_only_c1;
        !ctrl_wr && tog_c1 && !tog_m0 && !tog_m1 && !tog_c0;
    endsequence

    // Software commands
    a_cmd_toggle: assert property (
        ctrl_wr && cmd == TFC_CMD_TOGGLE |=> tff_r != $past(tff_r))
        else $error("Toggle command did not invert the output");

    a_cmd_set: assert property (
        ctrl_wr && cmd == TFC_CMD_SET |=> tff_r)
        else $error("Set command did not raise the output");

    a_cmd_clear: assert property (
        ctrl_wr && cmd == TFC_CMD_CLEAR |=> !tff_r)
        else $error("Clear command did not lower the output");

    a_cmd_keep: assert property (
        ctrl_wr && cmd == TFC_CMD_KEEP && !tog_evt |=> $stable(tff_r))
        else $error("Keep command changed the output");

    a_ctrl_readback: assert property (
        s_ctrl_read |-> rdata_r[7:6] == 2'h3 && rdata_r[1:0] == 2'h3)
        else $error("Control read-back fixed bits are not ones");

    // Event toggling
    a_match1_toggle: assert property (
        s_only_m1 |=> tff_r != $past(tff_r))
        else $error("Enabled match one did not toggle the output");

    a_match0_toggle: assert property (
        s_only_m0 |=> tff_r != $past(tff_r))
        else $error("Enabled match zero did not toggle the output");

    a_cap0_toggle: assert property (
        s_only_c0 |=> tff_r != $past(tff_r))
        else $error("Enabled capture zero did not toggle the output");

    a_cap1_toggle: assert property (
        s_only_c1 |=> tff_r != $past(tff_r))
        else $error("Enabled capture one did not toggle the output");

    a_output_hold: assert property (
        s_quiet |=> $stable(tff_r))
        else $error("Output changed with no enabled event");

    a_enable_reset: assert property (
        $past(!RSTN_I) |-> en_r == 4'h0 && stat_r == 3'h0)
        else $error("Enables or status not cleared by reset");

    // Status flags
    a_match0_flag: assert property (
        EVT_I.match0 |=> stat_r[0] ##1 1'b1)
        else $error("Match zero did not set status bit 0");

    a_match1_flag: assert property (
        EVT_I.match1 |=> stat_r[1])
        else $error("Match one did not set status bit 1");

    a_ovf_flag: assert property (
        EVT_I.overflow |=> stat_r[2])
        else $error("Overflow did not set status bit 2");

    a_flag_source: assert property (
        !stat_r[0] ##1 stat_r[0] |-> $past(EVT_I.match0))
        else $error("Status bit 0 set without a match");

    a_stat_sticky: assert property (
        !stat_rd |=> (stat_r & $past(stat_r)) == $past(stat_r))
        else $error("Status bit lost without a status read");

    a_stat_clear: assert property (
        stat_rd |=> stat_r == $past(stat_set))
        else $error("Status read did not clear the flags");

endmodule

// File: testbench/testbench.sv
// Self-checking testbench for the timer flip-flop control and status block
`timescale 1ns/10ps
module testbench;
    import tfc_pkg::*;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    tfc_evt_t    evt = '0;
    logic        tff, irq, awv = 1'b0, awr, wv = 1'b0, wr_rdy, bv, arv = 1'b0, arr, rv;
    logic [31:0] awa = '0, wd = '0, ara = '0, rdata, rd;
    logic [1:0]  bresp, rresp, rs;
    logic        tff_e;
    logic [3:0]  en_e;
    logic [2:0]  st_e, mask_e;
    int          error_cnt = 0, comparisons = 0, i, k;

    always #10 clk = ~clk;

    tfc_top dut (.CLK_I(clk), .RSTN_I(rstn), .EVT_I(evt), .TFF_O(tff), .IRQ_O(irq),
        .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_AWADDR_I(awa),
        .S_AXI_AWPROT_I(3'h0), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wr_rdy),
        .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hf), .S_AXI_BVALID_O(bv),
        .S_AXI_BREADY_I(1'b1), .S_AXI_BRESP_O(bresp), .S_AXI_ARVALID_I(arv),
        .S_AXI_ARREADY_O(arr), .S_AXI_ARADDR_I(ara), .S_AXI_ARPROT_I(3'h0),
        .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(1'b1), .S_AXI_RDATA_O(rdata),
        .S_AXI_RRESP_O(rresp));

    function automatic logic [31:0] ctrl_e();
        return {24'h0, TFC_FIXED_ONES, en_e, 2'h3};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ap, wp, at, wt, b;
        logic [1:0] r;
        awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; ap = 1'b1; wp = 1'b1; b = 1'b0;
        while (ap || wp)
        begin
            @(negedge clk); at = ap && awr; wt = wp && wr_rdy;
            @(posedge clk);
            if (at) begin awv <= 1'b0; ap = 1'b0; end
            if (wt) begin wv <= 1'b0; wp = 1'b0; end
        end
        while (!b)
        begin
            @(negedge clk); b = bv; r = bresp;
            @(posedge clk);
        end
        chk({30'h0, r}, {30'h0, er}, "bresp");
    endtask

    task automatic rdchk(input logic [31:0] a, input logic [31:0] exp, input logic [1:0] er);
        logic t, v;
        ara <= a; arv <= 1'b1; t = 1'b0; v = 1'b0;
        while (!t)
        begin
            @(negedge clk); t = arr;
            @(posedge clk);
        end
        arv <= 1'b0;
        while (!v)
        begin
            @(negedge clk); v = rv; rd = rdata; rs = rresp;
            @(posedge clk);
        end
        chk(rd, exp, "rdata");
        chk({30'h0, rs}, {30'h0, er}, "rresp");
    endtask

    task automatic pins();
        @(negedge clk);
        chk({31'h0, tff}, {31'h0, tff_e}, "tff");
        chk({31'h0, irq}, {31'h0, |(st_e & mask_e)}, "irq");
        @(posedge clk);
    endtask

    task automatic pulse(input tfc_evt_t e);
        evt <= e;
        @(posedge clk);
        evt <= '0;
        tff_e ^= ^(e[4:1] & en_e);
        st_e |= {e.overflow, e.match1, e.match0};
        pins();
    endtask

    task automatic wrap_up();
        if (error_cnt == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (30000) @(posedge clk);
        error_cnt++;
        wrap_up();
    end

    initial
    begin
        k = $urandom(70);
        tff_e = 1'b0; en_e = 4'h0; st_e = 3'h0; mask_e = 3'h0;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        pins();
        rdchk(TFC_CTRL_OFS, 32'hc3, TFC_RESP_OKAY);
        rdchk(TFC_STAT_OFS, 32'h0, TFC_RESP_OKAY);
        rdchk(TFC_MASK_OFS, 32'h0, TFC_RESP_OKAY);
        for (i = 0; i < 6; i++)
        begin
            k = (i < 4) ? (i + 1) % 4 : i - 4;
            wr(TFC_CTRL_OFS, {24'h0, 2'h3, 4'h0, 2'(k)}, TFC_RESP_OKAY);
            tff_e = (k == 0) ? ~tff_e : (k == 1) ? 1'b1 : (k == 2) ? 1'b0 : tff_e;
            pins();
        end
        for (i = 0; i < 40; i++)
        begin
            en_e = (i == 0) ? 4'hf : 4'($urandom);
            mask_e = 3'($urandom);
            wr(TFC_CTRL_OFS, {8'($urandom), 16'h0, 2'h3, en_e, 2'h3}, TFC_RESP_OKAY);
            wr(TFC_MASK_OFS, {29'h0, mask_e}, TFC_RESP_OKAY);
            rdchk(TFC_CTRL_OFS, ctrl_e(), TFC_RESP_OKAY);
            pulse((i == 0) ? 5'h1f : 5'($urandom));
            pulse(5'($urandom));
            wr(TFC_STAT_OFS, 32'hffffffff, TFC_RESP_OKAY);
            rdchk(TFC_STAT_OFS, {29'h0, st_e}, TFC_RESP_OKAY);
            st_e = 3'h0;
            pins();
        end
        wr(32'hfffff150, 32'hff, TFC_RESP_SLVERR);
        rdchk(32'hfffff150, 32'h0, TFC_RESP_SLVERR);
        rdchk(TFC_CTRL_OFS, ctrl_e(), TFC_RESP_OKAY);
        wrap_up();
    end
endmodule
